/* src/tcc_channel.sv */
// Purpose: one timer channel resolving bus access against counter events
// Assumes: bus states arrive as one-cycle strobes; events are one-cycle pulses
// Notes:   all outputs registered; match and capture show one cycle late
`timescale 1ns/100ps
`include "tcc_regs.svh"
module tcc_channel (
	input  wire logic              i_ref_clk,
	input  wire logic              i_rst,
	input  wire logic              i_inc,
	input  wire logic              i_count_down,
	input  wire logic              i_cap_a,
	input  wire logic              i_cap_b,
	input  wire tcc_pkg::tcc_clr_e i_clear_select,
	input  wire logic              i_channel_sync_bit,
	input  wire logic              i_pulse_mode_bit,
	input  wire logic [2:0]        i_io_a,
	input  wire logic [2:0]        i_io_b,
	input  wire logic              i_buffer_a,
	input  wire logic              i_buffer_b,
	input  wire logic              i_sync_clear,
	input  wire logic              i_sync_load,
	input  wire logic [15:0]       i_sync_data,
	input  wire logic              i_wrap_clear,
	input  wire logic              i_wr_t2,
	input  wire logic              i_wr_t3,
	input  wire tcc_pkg::tcc_sel_e i_wr_sel,
	input  wire logic [1:0]        i_wr_be,
	input  wire logic [15:0]       i_wr_data,
	input  wire logic              i_rd_t3,
	input  wire tcc_pkg::tcc_sel_e i_rd_sel,
	output logic [15:0]            o_count,
	output logic [15:0]            o_gra,
	output logic [15:0]            o_grb,
	output logic [15:0]            o_bra,
	output logic [15:0]            o_brb,
	output logic                   o_match_a,
	output logic                   o_match_b,
	output logic                   o_capture_a,
	output logic                   o_capture_b,
	output logic                   o_wrap_flag,
	output logic                   o_clear_out,
	output logic                   o_sync_load,
	output logic [15:0]            o_sync_data,
	output logic [15:0]            o_rd_data
);
	import tcc_pkg::*;

	tcc_chan_s   st_q;
	tcc_chan_s   st_d;
	tcc_gr_s     gr_st [2];
	logic [1:0]  match_raw;
	logic [1:0]  cap_fire;
	logic [1:0]  match_ok;
	logic [1:0]  match_eff;
	logic [1:0]  ev;
	logic [1:0]  wr_gr;
	logic [1:0]  wr_br;
	logic [1:0]  is_cap;
	logic [1:0]  buf_en;
	logic [1:0]  cap_in;
	logic        cnt_wr;
	logic        byte_wr;
	logic        inc_block;
	logic        tick;
	logic        clear_ev;
	logic        wrap_ev;
	logic [15:0] cnt_merged;

	function automatic logic sel_hit(input logic stb, input tcc_sel_e sel,
		input tcc_sel_e want);
		sel_hit = stb & (sel == want);
	endfunction : sel_hit

	assign wr_gr[0] = sel_hit(i_wr_t3, i_wr_sel, TCC_SEL_GRA);
	assign wr_gr[1] = sel_hit(i_wr_t3, i_wr_sel, TCC_SEL_GRB);
	assign wr_br[0] = sel_hit(i_wr_t3, i_wr_sel, TCC_SEL_BRA);
	assign wr_br[1] = sel_hit(i_wr_t3, i_wr_sel, TCC_SEL_BRB);
	// role bit picks compare or capture
	assign is_cap   = {i_io_b[`TCC_ROLE_BIT], i_io_a[`TCC_ROLE_BIT]};
	assign buf_en   = {i_buffer_b, i_buffer_a};
	assign cap_in   = {i_cap_b, i_cap_a};

	// simultaneous A and B matches inhibited in PWM mode
	assign match_ok[0] = ~(i_pulse_mode_bit & match_raw[1]);
	assign match_ok[1] = ~(i_pulse_mode_bit & match_raw[0]);
	assign match_eff = match_raw & match_ok;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_gr
			tcc_gr_unit u_gr (
				.i_ref_clk    (i_ref_clk),
				.i_rst        (i_rst),
				.i_count      (st_q.count),
				.i_tick       (tick),
				.i_is_capture (is_cap[g]),
				.i_pwm        (i_pulse_mode_bit),
				.i_buffer_en  (buf_en[g]),
				.i_cap_pulse  (cap_in[g]),
				.i_match_ok   (match_ok[g]),
				.i_wr_gr      (wr_gr[g]),
				.i_wr_br      (wr_br[g]),
				.i_be         (i_wr_be),
				.i_wr_data    (i_wr_data),
				.o_state      (gr_st[g]),
				.o_match_raw  (match_raw[g]),
				.o_cap_fire   (cap_fire[g])
			);
		end
	endgenerate

	always_comb begin
		st_d = st_q;
		cnt_wr = sel_hit(i_wr_t3, i_wr_sel, TCC_SEL_COUNT);
		byte_wr = (i_wr_be != `TCC_BE_WORD);
		// word write blocks in T3; byte write blocks in T2 and T3
		inc_block = cnt_wr | (sel_hit(i_wr_t2, i_wr_sel, TCC_SEL_COUNT) & byte_wr);
		tick = i_inc;
		ev = match_eff | cap_fire;
		unique case (i_clear_select)
			TCC_CLR_A:    clear_ev = ev[0];
			TCC_CLR_B:    clear_ev = ev[1];
			TCC_CLR_SYNC: clear_ev = i_sync_clear & i_channel_sync_bit;
			TCC_CLR_NONE: clear_ev = 1'b0;
		endcase
		// wrap seen even when the write swallows the count
		wrap_ev = tick & ~clear_ev & (i_count_down ? (st_q.count == `TCC_COUNT_MIN)
			: (st_q.count == `TCC_COUNT_MAX));
		cnt_merged = tcc_merge(st_q.count, i_wr_data, i_wr_be);
		// clear wins over write; clear wins over increment
		if (clear_ev) begin
			st_d.count = `TCC_COUNT_RST;
		end else if (cnt_wr) begin
			st_d.count = cnt_merged;
		end else if (i_sync_load & i_channel_sync_bit) begin
			st_d.count = i_sync_data;
		end else if (tick & ~inc_block) begin
			st_d.count = i_count_down ? st_q.count - 16'h0001 : st_q.count + 16'h0001;
		end
		// Set wins over a software clear in the same cycle
		st_d.wrap = wrap_ev | (st_q.wrap & ~i_wrap_clear);
		// broadcast full 16-bit value to synchronized peers
		st_d.sync_load = cnt_wr & ~clear_ev & i_channel_sync_bit;
		st_d.sync_data = cnt_merged;
		st_d.clear_out = clear_ev;
		st_d.match = match_eff;
		st_d.cap = cap_fire;
		// read samples registers before this cycle's capture
		if (i_rd_t3) begin
			unique case (i_rd_sel)
				TCC_SEL_COUNT: st_d.rd_data = st_q.count;
				TCC_SEL_GRA:   st_d.rd_data = gr_st[0].gr;
				TCC_SEL_GRB:   st_d.rd_data = gr_st[1].gr;
				TCC_SEL_BRA:   st_d.rd_data = gr_st[0].br;
				TCC_SEL_BRB:   st_d.rd_data = gr_st[1].br;
				default:       st_d.rd_data = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			st_q <= '{count: `TCC_COUNT_RST, wrap: 1'b0, rd_data: 16'h0000,
				match: 2'h0, cap: 2'h0, clear_out: 1'b0, sync_load: 1'b0,
				sync_data: 16'h0000};
		end else begin
			st_q <= st_d;
		end
	end

	// Sub-unit flags equal st_q copies; both registered on the same edge
	assign o_count     = st_q.count;
	assign o_gra       = gr_st[0].gr;
	assign o_grb       = gr_st[1].gr;
	assign o_bra       = gr_st[0].br;
	assign o_brb       = gr_st[1].br;
	assign o_match_a   = st_q.match[0];
	assign o_match_b   = st_q.match[1];
	assign o_capture_a = st_q.cap[0];
	assign o_capture_b = st_q.cap[1];
	assign o_wrap_flag = st_q.wrap;
	assign o_clear_out = st_q.clear_out;
	assign o_sync_load = st_q.sync_load;
	assign o_sync_data = st_q.sync_data;
	assign o_rd_data   = st_q.rd_data;

	a_clear_beats_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		clear_ev && cnt_wr |=> o_count == 16'h0000)
		else $error("counter write survived a clear");

	a_word_write_wins: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		cnt_wr && !clear_ev && i_wr_be == 2'h3 && i_inc
		|=> o_count == $past(i_wr_data))
		else $error("word write lost to increment");

	a_byte_write_keep: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		cnt_wr && !clear_ev && i_wr_be == 2'h1
		|=> o_count[15:8] == $past(o_count[15:8])
		&& o_count[7:0] == $past(i_wr_data[7:0]))
		else $error("byte write disturbed the other byte");

	a_byte_t2_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_wr_t2 && !i_wr_t3 && i_wr_sel == TCC_SEL_COUNT && i_wr_be != 2'h3
		&& !clear_ev && !(i_sync_load && i_channel_sync_bit)
		|=> $stable(o_count))
		else $error("count moved in T2 of byte write");

	a_gr_write_nomatch: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		wr_gr[0] |=> !o_match_a)
		else $error("match raised during register write");

	a_wrap_under_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		cnt_wr && !clear_ev && i_inc && !i_count_down && o_count == 16'hFFFF
		|=> o_wrap_flag && o_count == $past(cnt_merged))
		else $error("wrap flag missed under write");

	a_read_precapture: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_rd_t3 && i_rd_sel == TCC_SEL_GRA |=> o_rd_data == $past(o_gra))
		else $error("read returned captured value");

	a_capture_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		cap_fire[0] && i_clear_select == TCC_CLR_A && i_inc
		|=> o_count == 16'h0000 && o_gra == $past(o_count))
		else $error("capture clear mishandled");

	a_capture_beats_wr: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		cap_fire[1] && wr_gr[1] |=> o_grb == $past(o_count))
		else $error("register write beat capture");

	a_match_period: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_clear_select == TCC_CLR_B && match_eff[1]
		|-> o_count == o_grb ##1 o_count == 16'h0000 && o_match_b)
		else $error("compare clear off by one");

	a_buffer_capture: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		cap_fire[0] && i_buffer_a && wr_br[0] |=> o_bra == $past(o_gra))
		else $error("buffer write beat capture transfer");

	a_sync_broadcast: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		cnt_wr && !clear_ev && i_channel_sync_bit
		|=> o_sync_load && o_sync_data == o_count)
		else $error("synchronized counters not loaded");

	a_pwm_inhibit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_pulse_mode_bit |=> !(o_match_a && o_match_b) && !o_capture_a)
		else $error("PWM mode match or capture leaked");

	a_sync_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_clear_select == TCC_CLR_SYNC && i_sync_clear && !i_channel_sync_bit
		&& !cnt_wr && !i_inc && !i_sync_load |=> $stable(o_count))
		else $error("sync clear without sync bit");

	a_role_compare: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!i_io_a[2] |=> !o_capture_a)
		else $error("capture in compare role");

	a_role_compare_b: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!i_io_b[2] |=> !o_capture_b)
		else $error("capture in compare role on B");

	a_role_capture: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_io_a[2] && i_io_b[2] |=> !o_match_a && !o_match_b)
		else $error("match raised in capture role");

	a_grb_write_nomatch: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		wr_gr[1] |=> !o_match_b)
		else $error("match B raised during register write");

	a_byte_high_keep: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		cnt_wr && !clear_ev && i_wr_be == 2'h2
		|=> o_count[7:0] == $past(o_count[7:0])
		&& o_count[15:8] == $past(i_wr_data[15:8]))
		else $error("high byte write disturbed the low byte");

	a_wrap_set_wins: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		wrap_ev |=> o_wrap_flag)
		else $error("wrap event lost");

	a_wrap_sticky: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_wrap_flag && !i_wrap_clear |=> o_wrap_flag)
		else $error("wrap flag dropped without a clear");

	a_clear_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		clear_ev |=> o_clear_out && o_count == 16'h0000)
		else $error("clear event without zero count");

	a_sync_clear_on: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_clear_select == TCC_CLR_SYNC && i_sync_clear && i_channel_sync_bit
		|=> o_count == 16'h0000)
		else $error("sync clear ignored with sync bit set");

	a_pwm_no_cap_b: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_pulse_mode_bit |=> !o_capture_b)
		else $error("PWM mode capture B leaked");
endmodule : tcc_channel

/* src/tcc_regs.svh */
// Purpose: constants of the timer channel contention block
// Assumes: one system clock, bus states given as strobes
// Notes:   fields, reset values and codes only
//
// Summary of operation
// - Counter clear in the final write state wins; the written count is lost.
// - Word write to the counter in its final state wins over an increment.
// - Byte write in second or third state skips the increment; other byte kept.
// - General register write in final state suppresses that compare match.
// - Overflow or underflow during counter write: write wins, wrap flag still set.
// - Register read in final state returns the value from before a capture.
// - Capture clear plus increment: counter clears, pre-clear count is captured.
// - Capture in final state of a general register write wins; write dropped.
// - Clear by compare match happens in the last matching state: period N+1.
// - Capture buffering beats a buffer register write in its final state.
// - Synchronized byte write loads all synchronized counters with the full value.
// - PWM mode has no capture; simultaneous matches A and B are suppressed.
// - Clear select 01 clears on A, 10 on B, 11 synchronous with sync bit.
// - Role bit 2 of each control field: 0 output compare, 1 input capture.
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

`define TCC_COUNT_RST   16'h0000
`define TCC_GR_RST      16'hFFFF
`define TCC_BR_RST      16'hFFFF
`define TCC_COUNT_MAX   16'hFFFF
`define TCC_COUNT_MIN   16'h0000
`define TCC_ROLE_BIT    2
`define TCC_BE_LOW      2'h1
`define TCC_BE_HIGH     2'h2
`define TCC_BE_WORD     2'h3

`endif

/* src/tcc_pkg.sv */
// Purpose: types shared by the timer channel files
// Assumes: tcc_regs.svh holds the numbers
// Notes:   merge is used for every byte-wise write
package tcc_pkg;
	typedef enum logic [1:0] {
		TCC_CLR_NONE = 2'h0,
		TCC_CLR_A    = 2'h1,
		TCC_CLR_B    = 2'h2,
		TCC_CLR_SYNC = 2'h3
	} tcc_clr_e;

	typedef enum logic [2:0] {
		TCC_SEL_COUNT = 3'h0,
		TCC_SEL_GRA   = 3'h1,
		TCC_SEL_GRB   = 3'h2,
		TCC_SEL_BRA   = 3'h3,
		TCC_SEL_BRB   = 3'h4
	} tcc_sel_e;

	typedef struct packed {
		logic [15:0] gr;
		logic [15:0] br;
		logic        match;
		logic        cap;
	} tcc_gr_s;

	typedef struct packed {
		logic [15:0] count;
		logic        wrap;
		logic [15:0] rd_data;
		logic [1:0]  match;
		logic [1:0]  cap;
		logic        clear_out;
		logic        sync_load;
		logic [15:0] sync_data;
	} tcc_chan_s;

	// Byte-enable merge of a write into a 16-bit value
	function automatic logic [15:0] tcc_merge(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] be);
		tcc_merge = {be[1] ? new_v[15:8] : old_v[15:8],
			be[0] ? new_v[7:0] : old_v[7:0]};
	endfunction : tcc_merge
endpackage : tcc_pkg

/* src/tcc_gr_unit.sv */
// Purpose: one general register with its buffer register
// Assumes: count and tick come from the channel counter
// Notes:   match pulse is raw, the channel gates it; capture is gated here by role and PWM
`timescale 1ns/100ps
`include "tcc_regs.svh"
module tcc_gr_unit (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	input  wire logic [15:0] i_count,
	input  wire logic        i_tick,
	input  wire logic        i_is_capture,
	input  wire logic        i_pwm,
	input  wire logic        i_buffer_en,
	input  wire logic        i_cap_pulse,
	input  wire logic        i_match_ok,
	input  wire logic        i_wr_gr,
	input  wire logic        i_wr_br,
	input  wire logic [1:0]  i_be,
	input  wire logic [15:0] i_wr_data,
	output tcc_pkg::tcc_gr_s o_state,
	output logic             o_match_raw,
	output logic             o_cap_fire
);
	import tcc_pkg::*;

	tcc_gr_s st_q;
	tcc_gr_s st_d;

	always_comb begin
		st_d = st_q;
		// role from bit 2; no capture in PWM
		o_cap_fire = i_cap_pulse & i_is_capture & ~i_pwm;
		// match in last matching state; write kills it
		o_match_raw = i_tick & ~i_is_capture & (i_count == st_q.gr) & ~i_wr_gr;
		st_d.match = o_match_raw & i_match_ok;
		st_d.cap = o_cap_fire;
		// capture beats write; capture takes pre-clear count
		if (o_cap_fire) begin
			st_d.gr = i_count;
		end else if (i_wr_gr) begin
			st_d.gr = tcc_merge(st_q.gr, i_wr_data, i_be);
		end else if (i_buffer_en & o_match_raw & i_match_ok) begin
			st_d.gr = st_q.br;
		end
		if (o_cap_fire & i_buffer_en) begin
			st_d.br = st_q.gr;
		end else if (i_wr_br) begin
			st_d.br = tcc_merge(st_q.br, i_wr_data, i_be);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			st_q <= '{gr: `TCC_GR_RST, br: `TCC_BR_RST, match: 1'b0, cap: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign o_state = st_q;
endmodule : tcc_gr_unit

/* testbench/tcc_cpu_model.sv */
// Purpose: CPU-side model running register write and read bus cycles
// Assumes: strobes change 1 ns after the rising edge
// Notes:   a released data bus shows the inverse of its last value
`timescale 1ns/100ps
module tcc_cpu_model (
	input  wire logic         i_ref_clk,
	output logic              o_wr_t2,
	output logic              o_wr_t3,
	output tcc_pkg::tcc_sel_e o_wr_sel,
	output logic [1:0]        o_wr_be,
	output logic [15:0]       o_wr_data,
	output logic              o_rd_t3,
	output tcc_pkg::tcc_sel_e o_rd_sel
);
	import tcc_pkg::*;
	initial begin
		o_wr_t2   = 1'b0;
		o_wr_t3   = 1'b0;
		o_wr_sel  = TCC_SEL_COUNT;
		o_wr_be   = 2'h3;
		o_wr_data = 16'h0000;
		o_rd_t3   = 1'b0;
		o_rd_sel  = TCC_SEL_COUNT;
	end
	// Select and data held from T2 through the T3 edge
	task automatic wr(input tcc_sel_e sel, input logic [1:0] be, input logic [15:0] d);
		@(posedge i_ref_clk);
		#1;
		o_wr_sel  = sel;
		o_wr_be   = be;
		o_wr_data = d;
		o_wr_t2   = 1'b1;
		@(posedge i_ref_clk);
		#1;
		o_wr_t2 = 1'b0;
		o_wr_t3 = 1'b1;
		@(posedge i_ref_clk);
		#1;
		o_wr_t3   = 1'b0;
		o_wr_data = ~d;
	endtask : wr
	task automatic rd(input tcc_sel_e sel);
		@(posedge i_ref_clk);
		#1;
		o_rd_sel = sel;
		o_rd_t3  = 1'b1;
		@(posedge i_ref_clk);
		#1;
		o_rd_t3 = 1'b0;
	endtask : rd
endmodule : tcc_cpu_model

/* testbench/testbench.sv */
// Purpose: self-checking bench for the timer channel contention block
// Assumes: inputs change 1 ns after the rising edge
// Notes:   event pulses are forked against bus states to force clashes
`timescale 1ns/100ps
module testbench;
	import tcc_pkg::*;
	logic        clk, rst, inc, down, cap_a, cap_b, sbit, pwm, buf_a, buf_b;
	logic        sclr, sld, wclr, wr_t2, wr_t3, rd_t3, seen_clr;
	logic        m_a, m_b, c_a, c_b, wrap, clr_o, sld_o;
	logic [2:0]  io_a, io_b;
	logic [1:0]  be;
	logic [4:0]  seen;
	logic [15:0] sdat, wdat, cnt, gra, grb, bra, brb, sdat_o, rdat;
	tcc_clr_e    csel;
	tcc_sel_e    wsel, rsel;
	int          n_errors, n_tests, cyc, n;

	tcc_channel DUT (
		.i_ref_clk(clk), .i_rst(rst), .i_inc(inc), .i_count_down(down),
		.i_cap_a(cap_a), .i_cap_b(cap_b), .i_clear_select(csel),
		.i_channel_sync_bit(sbit), .i_pulse_mode_bit(pwm), .i_io_a(io_a), .i_io_b(io_b),
		.i_buffer_a(buf_a), .i_buffer_b(buf_b), .i_sync_clear(sclr), .i_sync_load(sld),
		.i_sync_data(sdat), .i_wrap_clear(wclr), .i_wr_t2(wr_t2), .i_wr_t3(wr_t3),
		.i_wr_sel(wsel), .i_wr_be(be), .i_wr_data(wdat), .i_rd_t3(rd_t3), .i_rd_sel(rsel),
		.o_count(cnt), .o_gra(gra), .o_grb(grb), .o_bra(bra), .o_brb(brb),
		.o_match_a(m_a), .o_match_b(m_b), .o_capture_a(c_a), .o_capture_b(c_b),
		.o_wrap_flag(wrap), .o_clear_out(clr_o), .o_sync_load(sld_o),
		.o_sync_data(sdat_o), .o_rd_data(rdat)
	);
	tcc_cpu_model CPU (
		.i_ref_clk(clk), .o_wr_t2(wr_t2), .o_wr_t3(wr_t3), .o_wr_sel(wsel),
		.o_wr_be(be), .o_wr_data(wdat), .o_rd_t3(rd_t3), .o_rd_sel(rsel)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Pulses are one cycle wide, so they are gathered here and checked later
	always @(posedge clk) begin
		seen <= seen_clr ? 5'h00 : seen | {c_b, clr_o, c_a, m_b, m_a};
		cyc  <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk16
	task automatic chk1(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %b, seen %b", nm, e, g);
		end
	endtask : chk1
	// Event pulse d edges later: {sync load, wrap clear, sync clear, cap a, cap b, inc}
	task automatic ev(input int d, input logic [5:0] e);
		repeat (d) @(posedge clk);
		#1;
		{sld, wclr, sclr, cap_a, cap_b, inc} = e;
		@(posedge clk);
		#1;
		{sld, wclr, sclr, cap_a, cap_b, inc} = 6'h00;
	endtask : ev
	// Only the collector writes seen; this asks it to start afresh
	task automatic clr_seen();
		seen_clr = 1'b1;
		@(posedge clk);
		#1;
		seen_clr = 1'b0;
	endtask : clr_seen
	task automatic step();
		repeat (2) @(posedge clk);
		#1;
	endtask : step
	task automatic wrap_up();
		$display("errors %0d, comparisons %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	initial begin
		{rst, down, pwm, sbit, buf_a, buf_b} = 6'h20;
		{sld, wclr, sclr, cap_a, cap_b, inc} = 6'h00;
		{io_a, io_b} = 6'h1B;
		csel = TCC_CLR_NONE;
		sdat = 16'h0000;
		seen_clr = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		chk16("count", 16'h0000, cnt);
		chk16("gra", 16'hFFFF, gra);
		chk16("brb", 16'hFFFF, brb);
		chk1("wrap", 1'b0, wrap);
		fork CPU.wr(TCC_SEL_COUNT, 2'h3, 16'h1234); ev(2, 6'h01); join
		chk16("count", 16'h1234, cnt);
		fork CPU.wr(TCC_SEL_COUNT, 2'h2, 16'hAB00); ev(1, 6'h01); join
		chk16("count", 16'hAB34, cnt);
		fork CPU.wr(TCC_SEL_COUNT, 2'h1, 16'h0056); ev(2, 6'h01); join
		chk16("count", 16'hAB56, cnt);
		CPU.wr(TCC_SEL_COUNT, 2'h3, 16'hFFFF);
		fork CPU.wr(TCC_SEL_COUNT, 2'h3, 16'h0010); ev(2, 6'h01); join
		step();
		chk16("count", 16'h0010, cnt);
		chk1("wrap", 1'b1, wrap);
		ev(1, 6'h10);
		chk1("wrap", 1'b0, wrap);
		down = 1'b1;
		CPU.wr(TCC_SEL_COUNT, 2'h3, 16'h0000);
		fork CPU.wr(TCC_SEL_COUNT, 2'h3, 16'h0020); ev(2, 6'h01); join
		step();
		chk16("count", 16'h0020, cnt);
		chk1("wrap", 1'b1, wrap);
		down = 1'b0;
		ev(1, 6'h10);
		sbit = 1'b1;
		CPU.wr(TCC_SEL_COUNT, 2'h2, 16'h5A00);
		chk1("sync load", 1'b1, sld_o);
		chk16("sync data", 16'h5A20, sdat_o);
		sdat = 16'h4321;
		ev(1, 6'h20);
		chk16("count", 16'h4321, cnt);
		csel = TCC_CLR_SYNC;
		clr_seen();
		fork CPU.wr(TCC_SEL_COUNT, 2'h3, 16'h5555); ev(2, 6'h08); join
		step();
		chk16("count", 16'h0000, cnt);
		chk1("clear out", 1'b1, seen[3]);
		sbit = 1'b0;
		CPU.wr(TCC_SEL_COUNT, 2'h3, 16'h0077);
		ev(1, 6'h08);
		chk16("count", 16'h0077, cnt);
		for (int i = 0; i < 2; i++) begin
			CPU.wr(i ? TCC_SEL_GRB : TCC_SEL_GRA, 2'h3, i ? 16'h0004 : 16'h0002);
			csel = i ? TCC_CLR_B : TCC_CLR_A;
			CPU.wr(TCC_SEL_COUNT, 2'h3, 16'h0000);
			clr_seen();
			n = 0;
			inc = 1'b1;
			do begin
				@(posedge clk);
				#1;
				n++;
			end while (cnt !== 16'h0000 && n < 40);
			inc = 1'b0;
			step();
			chk16("period", i ? 16'h0005 : 16'h0003, 16'(n));
			chk1("match", 1'b1, seen[i]);
		end
		csel = TCC_CLR_NONE;
		CPU.wr(TCC_SEL_GRA, 2'h3, 16'h0005);
		CPU.wr(TCC_SEL_COUNT, 2'h3, 16'h0005);
		clr_seen();
		fork CPU.wr(TCC_SEL_GRA, 2'h3, 16'h0009); ev(2, 6'h01); join
		step();
		chk1("match a", 1'b0, seen[0]);
		chk16("gra", 16'h0009, gra);
		chk16("count", 16'h0006, cnt);
		io_a = 3'h7;
		CPU.wr(TCC_SEL_COUNT, 2'h3, 16'h0042);
		clr_seen();
		fork CPU.wr(TCC_SEL_GRA, 2'h3, 16'h1111); ev(2, 6'h04); join
		step();
		chk16("gra", 16'h0042, gra);
		chk1("capture a", 1'b1, seen[2]);
		CPU.wr(TCC_SEL_COUNT, 2'h3, 16'h0099);
		fork CPU.rd(TCC_SEL_GRA); ev(1, 6'h04); join
		chk16("read", 16'h0042, rdat);
		chk16("gra", 16'h0099, gra);
		CPU.rd(tcc_sel_e'(3'h5));
		chk16("read", 16'h0000, rdat);
		buf_a = 1'b1;
		CPU.wr(TCC_SEL_COUNT, 2'h3, 16'h00A0);
		fork CPU.wr(TCC_SEL_BRA, 2'h3, 16'h2222); ev(2, 6'h04); join
		chk16("gra", 16'h00A0, gra);
		chk16("bra", 16'h0099, bra);
		buf_a = 1'b0;
		csel = TCC_CLR_A;
		CPU.wr(TCC_SEL_COUNT, 2'h3, 16'h0030);
		ev(1, 6'h05);
		chk16("count", 16'h0000, cnt);
		chk16("gra", 16'h0030, gra);
		csel = TCC_CLR_NONE;
		io_b = 3'h4;
		buf_b = 1'b1;
		clr_seen();
		fork CPU.wr(TCC_SEL_BRB, 2'h3, 16'h3333); ev(2, 6'h02); join
		chk16("grb", 16'h0000, grb);
		chk16("brb", 16'h0004, brb);
		step();
		chk1("capture b", 1'b1, seen[4]);
		buf_b = 1'b0;
		{io_a, io_b} = 6'h1B;
		pwm = 1'b1;
		CPU.wr(TCC_SEL_GRA, 2'h3, 16'h0007);
		CPU.wr(TCC_SEL_GRB, 2'h3, 16'h0007);
		CPU.wr(TCC_SEL_COUNT, 2'h3, 16'h0007);
		clr_seen();
		ev(1, 6'h01);
		{io_a, io_b} = 6'h3F;
		ev(1, 6'h06);
		step();
		chk16("seen", 16'h0000, {11'h000, seen});
		chk16("gra", 16'h0007, gra);
		wrap_up();
	end
endmodule : testbench
